// File: usc_pkg.sv
// Package: register map, field layout, encodings and carriers for the serial control block
package usc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CMD   = 8'h00;
	localparam logic [7:0] OFF_CFG   = 8'h04;
	localparam logic [7:0] OFF_IEN_S = 8'h08;
	localparam logic [7:0] OFF_IEN_C = 8'h0c;
	localparam logic [7:0] OFF_IEN   = 8'h10;
	localparam logic [7:0] OFF_FLAGS = 8'h14;
	localparam logic [7:0] OFF_RXC   = 8'h18;
	localparam logic [7:0] OFF_TXC   = 8'h1c;
	localparam logic [7:0] OFF_BRD   = 8'h20;
	localparam logic [7:0] OFF_RTO   = 8'h24;
	localparam logic [7:0] OFF_TTG   = 8'h28;
	localparam logic [7:0] OFF_FIDI  = 8'h40;
	localparam logic [7:0] OFF_NER   = 8'h44;
	localparam logic [7:0] OFF_IRF   = 8'h4c;
	localparam logic [7:0] OFF_WLC   = 8'he4;
	localparam logic [7:0] OFF_WLV   = 8'he8;
	// Reset values
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] RST_FIDI = 32'h0000_0174;
	// Command bit positions
	localparam int C_RXRST = 2;
	localparam int C_TXRST = 3;
	localparam int C_RXON  = 4;
	localparam int C_RXOFF = 5;
	localparam int C_TXON  = 6;
	localparam int C_TXOFF = 7;
	localparam int C_CLRST = 8;
	localparam int C_BRKB  = 9;
	localparam int C_BRKE  = 10;
	localparam int C_TOB   = 11;
	localparam int C_ADDR  = 12;
	localparam int C_CLRIT = 13;
	localparam int C_CLRNK = 14;
	localparam int C_TOR   = 15;
	localparam int C_RTSL  = 18;
	localparam int C_RTSH  = 19;
	// Status bit positions
	localparam int F_BREAK_RECEIVED_FLAG = 2;
	localparam int F_OVR   = 5;
	localparam int F_FRM   = 6;
	localparam int F_PAR   = 7;
	localparam int F_TMO   = 8;
	localparam int F_TXE   = 9;
	localparam int F_UNR   = 10;
	localparam int F_NACK  = 13;
	// Configuration fields
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_CLK_LSB  = 4;
	localparam int CFG_PAR_LSB  = 9;
	localparam int CFG_CHM_LSB  = 14;
	// Protection fields and key
	localparam int WL_KEY_LSB = 8;
	localparam logic [23:0] WL_KEY = 24'h55_5341;
	// Break tail in bit periods, clock cycles per bit period, and the multidrop parity code
	localparam int BRK_TAIL_BITS = 12;
	localparam logic [5:0] BIT_CYC = 6'd16;
	localparam logic [2:0] PAR_MULTIDROP = 3'd6;

	typedef enum logic [1:0] {ROUTE_NORMAL, ROUTE_ECHO, ROUTE_LOCAL, ROUTE_REMOTE} usc_route_e;
	typedef enum logic [3:0] {
		OPM_NORMAL = 4'h0, OPM_RS485 = 4'h1, OPM_HANDSHAKE = 4'h2, OPM_CARD0 = 4'h4,
		OPM_CARD1 = 4'h6, OPM_INFRARED = 4'h8, OPM_SPI_M = 4'he, OPM_SPI_S = 4'hf
	} usc_opmode_e;
	typedef enum logic [1:0] {CLK_MASTER = 2'd0, CLK_DIV8 = 2'd1, CLK_RSVD = 2'd2, CLK_EXT = 2'd3} usc_clksrc_e;

	typedef struct packed {
		logic       cyc;
		logic       stb;
		logic       we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} usc_wb_req_s;

	typedef struct packed {
		logic tx_line;
		logic rx_line;
	} usc_lines_s;
endpackage : usc_pkg

// File: usc_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module usc_sync (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic meta_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= 1'b1;
			q_o    <= 1'b1;
		end else if (ce_i) begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule : usc_sync

// File: usc_route.sv
// Channel routing between pins, transmitter and receiver
`timescale 1ns/1ns
module usc_route (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	input  wire usc_pkg::usc_route_e route_i,
	input  wire usc_pkg::usc_lines_s core_i,
	input  wire logic              rxd_i,
	output logic                   txd_o,
	output logic                   rx_core_o
);
	import usc_pkg::*;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			txd_o     <= 1'b1;
			rx_core_o <= 1'b1;
		end else if (ce_i) begin
			unique case (route_i)
				ROUTE_NORMAL: begin
					txd_o     <= core_i.tx_line;
					rx_core_o <= rxd_i;
				end
				ROUTE_ECHO: begin
					txd_o     <= rxd_i;
					rx_core_o <= rxd_i;
				end
				ROUTE_LOCAL: begin
					txd_o     <= 1'b1;
					rx_core_o <= core_i.tx_line;
				end
				ROUTE_REMOTE: begin
					txd_o     <= rxd_i;
					rx_core_o <= 1'b1;
				end
			endcase
		end
	end
endmodule : usc_route

// File: usc_ctrl.sv
`timescale 1ns/1ns
module usc_ctrl (
	input  wire logic      clk_i,
	input  wire logic      rst_i,
	input  wire logic      ce_i,
	input  wire logic      cyc_i,
	input  wire logic      stb_i,
	input  wire logic      we_i,
	input  wire logic [3:0] sel_i,
	input  wire logic [7:0] adr_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]    dat_o,
	output logic           ack_o,
	input  wire logic      rxd_i,
	input  wire logic      tx_core_i,
	input  wire logic      tx_idle_i,
	input  wire logic      rx_char_i,
	input  wire logic      par_err_i,
	input  wire logic      frm_err_i,
	input  wire logic      ovr_err_i,
	input  wire logic      unr_err_i,
	input  wire logic      rx_brk_i,
	input  wire logic      nack_i,
	input  wire logic      iter_i,
	input  wire logic      tmo_i,
	output logic           txd_o,
	output logic           rx_core_o,
	output logic           rts_n_o,
	output logic           tx_en_o,
	output logic           rx_en_o,
	output logic           tx_rst_o,
	output logic           rx_rst_o,
	output logic           addr_bit_o,
	output logic           brk_o,
	output logic           idle_wait_o,
	output logic [3:0]     op_mode_o,
	output logic [1:0]     clk_src_o
);
	import usc_pkg::*;

	logic [31:0] cfg_r, brd_r, rto_r, ttg_r, fidi_r, irf_r, ien_r;
	logic        write_lock_enable_r;
	logic        write_lock_violation_flag_r;
	logic [7:0]  violation_source_r;
	logic [13:0] flags_r;
	logic        addr_pend_r;
	logic        brk_pend_r;
	logic [1:0]  brk_ph_r;
	logic [9:0]  brk_cnt_r;
	logic        rxd_s;
	logic        wr, rd, cmd_wr, prot_hit, key_ok, spi_m, card;
	logic [31:0] cmd, rdata;
	usc_lines_s  core_lines;
	usc_route_e  route;

	usc_sync u_rx_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.d_i   (rxd_i),
		.q_o   (rxd_s)
	);

	assign route = usc_route_e'(cfg_r[CFG_CHM_LSB +: 2]);
	// One driver for the whole carrier; a break overrides the transmitter line
	assign core_lines = '{tx_line: brk_o ? 1'b0 : tx_core_i, rx_line: rxd_s};

	usc_route u_route (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.route_i   (route),
		.core_i    (core_lines),
		.rxd_i     (rxd_s),
		.txd_o     (txd_o),
		.rx_core_o (rx_core_o)
	);

	// Bus decode; each access acknowledged one cycle after the strobe
	assign wr      = cyc_i && stb_i && we_i && !ack_o;
	assign rd      = cyc_i && stb_i && !we_i && !ack_o;
	assign cmd_wr  = wr && (adr_i == OFF_CMD) && sel_i[0] && sel_i[1] && sel_i[2];
	assign cmd     = cmd_wr ? dat_i : RST_ZERO;
	assign key_ok  = dat_i[31:WL_KEY_LSB] == WL_KEY;
	assign prot_hit = wr && write_lock_enable_r && (adr_i == OFF_CFG || adr_i == OFF_BRD || adr_i == OFF_RTO ||
		adr_i == OFF_TTG || adr_i == OFF_FIDI || adr_i == OFF_IRF);
	assign op_mode_o = cfg_r[CFG_MODE_LSB +: 4];
	assign clk_src_o = cfg_r[CFG_CLK_LSB +: 2];
	assign spi_m   = op_mode_o == OPM_SPI_M;
	assign card    = op_mode_o == OPM_CARD0 || op_mode_o == OPM_CARD1;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_o <= 1'b0;
		else if (ce_i)
			ack_o <= cyc_i && stb_i && !ack_o;
	end

	// Protected configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_r  <= RST_ZERO;
			brd_r  <= RST_ZERO;
			rto_r  <= RST_ZERO;
			ttg_r  <= RST_ZERO;
			fidi_r <= RST_FIDI;
			irf_r  <= RST_ZERO;
		end else if (ce_i && wr && !write_lock_enable_r) begin
			unique case (adr_i)
				OFF_CFG:  cfg_r  <= dat_i;
				OFF_BRD:  brd_r  <= dat_i;
				OFF_RTO:  rto_r  <= dat_i;
				OFF_TTG:  ttg_r  <= dat_i;
				OFF_FIDI: fidi_r <= dat_i;
				OFF_IRF:  irf_r  <= dat_i;
				default: ;
			endcase
		end
	end

	// Write protection: enable, violation flag and its source
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			write_lock_enable_r         <= 1'b0;
			write_lock_violation_flag_r <= 1'b0;
			violation_source_r          <= 8'h00;
		end else if (ce_i) begin
			if (wr && adr_i == OFF_WLC && key_ok) begin
				write_lock_enable_r         <= dat_i[0];
				write_lock_violation_flag_r <= 1'b0;
			end
			if (prot_hit) begin
				write_lock_violation_flag_r <= 1'b1;
				violation_source_r          <= adr_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ien_r <= RST_ZERO;
		else if (ce_i && wr && adr_i == OFF_IEN_S)
			ien_r <= ien_r | dat_i;
		else if (ce_i && wr && adr_i == OFF_IEN_C)
			ien_r <= ien_r & ~dat_i;
	end

	// Transmitter and receiver enables and resets
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_en_o  <= 1'b0;
			rx_en_o  <= 1'b0;
			tx_rst_o <= 1'b0;
			rx_rst_o <= 1'b0;
		end else if (ce_i) begin
			tx_rst_o <= cmd[C_TXRST];
			rx_rst_o <= cmd[C_RXRST];
			if (route == ROUTE_REMOTE || cmd[C_TXOFF] || cmd[C_TXRST])
				tx_en_o <= 1'b0;
			else if (cmd[C_TXON])
				tx_en_o <= 1'b1;
			if (route == ROUTE_REMOTE || cmd[C_RXOFF] || cmd[C_RXRST])
				rx_en_o <= 1'b0;
			else if (cmd[C_RXON])
				rx_en_o <= 1'b1;
		end
	end

	// Status flags: a hardware event wins over a simultaneous clear
	always_ff @(posedge clk_i) begin
		if (rst_i)
			flags_r <= 14'h0000;
		else if (ce_i) begin
			if (cmd[C_CLRST]) begin
				flags_r[F_PAR]   <= 1'b0;
				flags_r[F_FRM]   <= 1'b0;
				flags_r[F_OVR]   <= 1'b0;
				flags_r[F_UNR]   <= 1'b0;
				flags_r[F_BREAK_RECEIVED_FLAG] <= 1'b0;
			end
			if (cmd[C_TOB])
				flags_r[F_TMO] <= 1'b0;
			if (cmd[C_CLRIT] && card)
				flags_r[F_UNR] <= 1'b0;
			if (cmd[C_CLRNK])
				flags_r[F_NACK] <= 1'b0;
			if (par_err_i) flags_r[F_PAR] <= 1'b1;
			if (frm_err_i) flags_r[F_FRM] <= 1'b1;
			if (ovr_err_i) flags_r[F_OVR] <= 1'b1;
			if (unr_err_i || iter_i) flags_r[F_UNR] <= 1'b1;
			if (rx_brk_i)  flags_r[F_BREAK_RECEIVED_FLAG] <= 1'b1;
			if (nack_i)    flags_r[F_NACK] <= 1'b1;
			if (tmo_i && !idle_wait_o) flags_r[F_TMO] <= 1'b1;
		end
	end

	// Time-out wait for first character; rearm restarts the wait
	always_ff @(posedge clk_i) begin
		if (rst_i)
			idle_wait_o <= 1'b0;
		else if (ce_i) begin
			if (cmd[C_TOB] || cmd[C_TOR])
				idle_wait_o <= 1'b1;
			else if (rx_char_i)
				idle_wait_o <= 1'b0;
		end
	end

	// Address marker for the next character, multidrop parity only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_pend_r <= 1'b0;
			addr_bit_o  <= 1'b0;
		end else if (ce_i) begin
			if (wr && adr_i == OFF_TXC) begin
				addr_bit_o  <= addr_pend_r;
				addr_pend_r <= 1'b0;
			end else if (cmd[C_ADDR] && cfg_r[CFG_PAR_LSB +: 3] == PAR_MULTIDROP)
				addr_pend_r <= 1'b1;
		end
	end

	// Break: wait empty, hold low at least one character, then twelve high bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			brk_pend_r <= 1'b0;
			brk_ph_r   <= 2'd0;
			brk_cnt_r  <= 10'd0;
			brk_o      <= 1'b0;
		end else if (ce_i) begin
			if (brk_cnt_r != 10'd0)
				brk_cnt_r <= brk_cnt_r - 10'd1;
			if (cmd[C_BRKB] && !brk_o && brk_ph_r == 2'd0)
				brk_pend_r <= 1'b1;
			if (brk_pend_r && tx_idle_i) begin
				brk_pend_r <= 1'b0;
				brk_o      <= 1'b1;
				brk_ph_r   <= 2'd1;
				brk_cnt_r  <= 10'(BIT_CYC * 6'd10);
			end else if (brk_ph_r == 2'd1 && cmd[C_BRKE])
				brk_ph_r <= 2'd2;
			else if (brk_ph_r == 2'd2 && brk_cnt_r == 10'd0) begin
				brk_o     <= 1'b0;
				brk_ph_r  <= 2'd3;
				brk_cnt_r <= 10'(BIT_CYC * 6'(BRK_TAIL_BITS));
			end else if (brk_ph_r == 2'd3 && brk_cnt_r == 10'd0)
				brk_ph_r <= 2'd0;
		end
	end

	// Request-to-send and SPI slave select share the pin
	always_ff @(posedge clk_i) begin
		if (rst_i)
			rts_n_o <= 1'b1;
		else if (ce_i) begin
			if (cmd[C_RTSH])
				rts_n_o <= 1'b1;
			else if (cmd[C_RTSL])
				rts_n_o <= 1'b0;
		end
	end

	always_comb begin
		rdata = RST_ZERO;
		unique case (adr_i)
			OFF_CFG:   rdata = cfg_r;
			OFF_IEN:   rdata = ien_r;
			OFF_FLAGS: rdata = {18'h0_0000, flags_r} | {22'h00_0000, tx_en_o & tx_idle_i, 9'h000};
			OFF_BRD:   rdata = brd_r;
			OFF_RTO:   rdata = rto_r;
			OFF_TTG:   rdata = ttg_r;
			OFF_FIDI:  rdata = fidi_r;
			OFF_IRF:   rdata = irf_r;
			OFF_WLC:   rdata = {31'h0000_0000, write_lock_enable_r};
			OFF_WLV:   rdata = {16'h0000, violation_source_r, 7'h00, write_lock_violation_flag_r};
			default:   rdata = RST_ZERO;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			dat_o <= RST_ZERO;
		else if (ce_i)
			dat_o <= rd ? rdata : RST_ZERO;
	end

	a_lock_blocks_cfg: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && wr && write_lock_enable_r && adr_i == OFF_CFG |=> $stable(cfg_r))
		else $error("locked configuration changed");
	a_violation_set: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && prot_hit |=> write_lock_violation_flag_r && violation_source_r == $past(adr_i))
		else $error("violation not recorded");
	a_wrong_key_kept: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && wr && adr_i == OFF_WLC && !key_ok |=> $stable(write_lock_enable_r))
		else $error("wrong key changed lock");
	a_local_tx_high: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && route == ROUTE_LOCAL ##1 ce_i && route == ROUTE_LOCAL |-> txd_o)
		else $error("transmit pin not high in local loopback");
	a_echo_copy: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && route == ROUTE_ECHO |=> txd_o == $past(rxd_s))
		else $error("echo did not copy receive line");
	a_remote_off: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && route == ROUTE_REMOTE |=> !tx_en_o && !rx_en_o)
		else $error("remote loopback left side enabled");
	a_enable_loses: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && cmd[C_TXON] && cmd[C_TXOFF] |=> !tx_en_o)
		else $error("enable won over disable");
	a_rts_low: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && cmd[C_RTSL] && !cmd[C_RTSH] |=> !rts_n_o)
		else $error("rts not driven low");
	a_status_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && cmd[C_CLRST] && !par_err_i |=> !flags_r[F_PAR])
		else $error("parity flag not cleared");
	a_strobe_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_rst_o |=> !tx_rst_o || $past(cmd[C_TXRST]))
		else $error("reset strobe held");
endmodule : usc_ctrl

// File: usc_peer.sv
// Far-side serial device model driving the receive pin
`timescale 1ns/1ns
module usc_peer (
	input  wire logic clk_i,
	input  wire logic drive_i,
	input  wire logic bit_i,
	output logic      rxd_o
);
	// Released line falls back to the high idle level, as a stop bit would leave it
	always_ff @(posedge clk_i) begin
		rxd_o <= drive_i ? bit_i : 1'b1;
	end
endmodule : usc_peer

// File: tb_usart_control_test_modes_wprot.sv
// Self-checking testbench for the serial control, routing and write-lock block
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin err_total++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module tb_usart_control_test_modes_wprot;
	import usc_pkg::*;
	localparam logic [31:0] ERRM = 32'h0000_04e4;
	localparam logic [31:0] ALLM = 32'h0000_25e4;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, tx_core_i, tx_idle_i, drv, lvl, rxd;
	logic [7:0]  adr_i;
	logic [31:0] dat_i, q, dat_o;
	logic [8:0]  ev;
	logic        ack_o, txd_o, rx_core_o, rts_n_o, tx_en_o, rx_en_o, tx_rst_o, rx_rst_o;
	logic        addr_bit_o, brk_o, idle_wait_o;
	logic [3:0]  op_mode_o;
	logic [1:0]  clk_src_o;
	int          err_total, comparisons, n_rst;

	usc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.sel_i(4'hf), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rxd_i(rxd),
		.tx_core_i(tx_core_i), .tx_idle_i(tx_idle_i), .rx_char_i(ev[0]), .par_err_i(ev[8]),
		.frm_err_i(ev[7]), .ovr_err_i(ev[6]), .unr_err_i(ev[5]), .rx_brk_i(ev[4]), .nack_i(ev[3]),
		.iter_i(ev[2]), .tmo_i(ev[1]), .txd_o(txd_o), .rx_core_o(rx_core_o), .rts_n_o(rts_n_o),
		.tx_en_o(tx_en_o), .rx_en_o(rx_en_o), .tx_rst_o(tx_rst_o), .rx_rst_o(rx_rst_o),
		.addr_bit_o(addr_bit_o), .brk_o(brk_o), .idle_wait_o(idle_wait_o), .op_mode_o(op_mode_o),
		.clk_src_o(clk_src_o));
	usc_peer peer (.clk_i(clk_i), .drive_i(drv), .bit_i(lvl), .rxd_o(rxd));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// Counting pulse cycles catches both a missing and a stretched reset strobe
	always @(posedge clk_i) n_rst += int'(tx_rst_o === 1'b1) + int'(rx_rst_o === 1'b1);

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		// No cycle count is assumed here; only the watchdog ends a hung wait
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask : wb
	task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, 32'h0000_0000);
		`CHK(nm, e, q)
	endtask : rd
	task st;
		@(negedge clk_i);
	endtask : st
	task cmd(input int b);
		wb(1'b1, OFF_CMD, 32'(1) << b);
	endtask : cmd

	task t_reset;
		rd(OFF_FIDI, RST_FIDI, "ratio");
		rd(OFF_WLC, RST_ZERO, "lock cfg");
		rd(OFF_WLV, RST_ZERO, "lock flag");
		rd(OFF_BRD, RST_ZERO, "divider");
		rd(8'h2c, RST_ZERO, "unmapped");
		st;
		`CHK("rts idle", 1'b1, rts_n_o)
	endtask : t_reset

	task t_route;
		logic v, et, er;
		wb(1'b1, OFF_CMD, (32'(1) << C_TXON) | (32'(1) << C_RXON));
		for (int r = 0; r < 4; r++) begin
			for (int b = 0; b < 2; b++) begin
				wb(1'b1, OFF_CFG, 32'(r) << CFG_CHM_LSB);
				v = b[0];
				lvl <= v;
				tx_core_i <= ~v;
				drv <= 1'b1;
				repeat (6) @(posedge clk_i);
				st;
				et = (r == 0) ? ~v : (r == 2) ? 1'b1 : v;
				er = (r == 2) ? ~v : (r == 3) ? 1'b1 : v;
				`CHK("txd", et, txd_o)
				`CHK("rx core", er, rx_core_o)
				if (r == 3) `CHK("enables", 2'b00, {tx_en_o, rx_en_o})
			end
		end
		drv <= 1'b0;
		tx_core_i <= 1'b1;
		wb(1'b1, OFF_CFG, 32'h0000_0000);
	endtask : t_route

	task t_cmd;
		int k;
		k = n_rst;
		wb(1'b1, OFF_CMD, (32'(1) << C_TXRST) | (32'(1) << C_RXRST));
		repeat (3) @(posedge clk_i);
		`CHK("reset pulses", k + 2, n_rst)
		wb(1'b1, OFF_CMD, (32'(1) << C_TXON) | (32'(1) << C_TXOFF) | (32'(1) << C_RXON));
		st;
		`CHK("tx en", 1'b0, tx_en_o)
		`CHK("rx en", 1'b1, rx_en_o)
		wb(1'b1, OFF_CFG, 32'(OPM_SPI_M));
		cmd(C_RTSL);
		st;
		`CHK("rts low", 1'b0, rts_n_o)
		cmd(C_RTSH);
		st;
		`CHK("rts high", 1'b1, rts_n_o)
	endtask : t_cmd

	task t_mode;
		logic [3:0] m [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'he, 4'hf};
		logic [1:0] c;
		for (int i = 0; i < 8; i++) begin
			c = (i % 3 == 2) ? 2'd3 : 2'(i % 3);
			wb(1'b1, OFF_CFG, {24'h0, 2'b00, c, m[i]});
			st;
			`CHK("op mode", m[i], op_mode_o)
			`CHK("clk src", c, clk_src_o)
			rd(OFF_CFG, {24'h0, 2'b00, c, m[i]}, "cfg read");
		end
	endtask : t_mode

	task t_flags;
		@(posedge clk_i);
		ev <= 9'h1ff;
		@(posedge clk_i);
		ev <= 9'h000;
		wb(1'b0, OFF_FLAGS, 32'h0000_0000);
		`CHK("flags set", ALLM, q & ALLM)
		cmd(C_CLRST);
		wb(1'b0, OFF_FLAGS, 32'h0000_0000);
		`CHK("flags clr", ALLM & ~ERRM, q & ALLM)
		cmd(C_CLRNK);
		wb(1'b0, OFF_FLAGS, 32'h0000_0000);
		`CHK("nack clr", 1'b0, q[F_NACK])
		cmd(C_TOB);
		st;
		`CHK("idle wait", 1'b1, idle_wait_o)
		wb(1'b0, OFF_FLAGS, 32'h0000_0000);
		`CHK("tmo clr", 1'b0, q[F_TMO])
		@(posedge clk_i);
		ev <= 9'h006;
		@(posedge clk_i);
		ev <= 9'h000;
		cmd(C_CLRIT);
		wb(1'b0, OFF_FLAGS, 32'h0000_0000);
		`CHK("tmo held", 1'b0, q[F_TMO])
		`CHK("iter kept", 1'b1, q[F_UNR])
		wb(1'b1, OFF_CFG, 32'(OPM_CARD0));
		cmd(C_CLRIT);
		wb(1'b0, OFF_FLAGS, 32'h0000_0000);
		`CHK("iter clr", 1'b0, q[F_UNR])
		@(posedge clk_i);
		ev <= 9'h001;
		@(posedge clk_i);
		ev <= 9'h000;
		st;
		`CHK("char seen", 1'b0, idle_wait_o)
		cmd(C_TOR);
		st;
		`CHK("rearm", 1'b1, idle_wait_o)
		wb(1'b1, OFF_CFG, 32'h0000_001f);
	endtask : t_flags

	task t_lock;
		wb(1'b1, OFF_WLC, {WL_KEY, 8'h01});
		wb(1'b1, OFF_CFG, 32'h0000_0001);
		st;
		`CHK("cfg locked", 4'hf, op_mode_o)
		wb(1'b1, OFF_BRD, 32'h0000_0005);
		rd(OFF_BRD, RST_ZERO, "div locked");
		rd(OFF_WLV, 32'h0000_2001, "violation");
		wb(1'b1, OFF_WLC, 32'h0000_0000);
		wb(1'b1, OFF_BRD, 32'h0000_0005);
		rd(OFF_BRD, RST_ZERO, "bad key");
		rd(OFF_WLV, 32'h0000_2001, "flag kept");
		wb(1'b1, OFF_WLC, {WL_KEY, 8'h00});
		rd(OFF_WLV, 32'h0000_2000, "flag clr");
		wb(1'b1, OFF_BRD, 32'h0000_0005);
		rd(OFF_BRD, 32'h0000_0005, "div open");
	endtask : t_lock

	task t_brk;
		wb(1'b1, OFF_CFG, 32'h0000_0000);
		tx_idle_i <= 1'b0;
		cmd(C_BRKB);
		repeat (20) @(posedge clk_i);
		st;
		`CHK("brk waits", 1'b0, brk_o)
		@(posedge clk_i);
		tx_idle_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		st;
		`CHK("brk on", 2'b10, {brk_o, txd_o})
		cmd(C_BRKB);
		cmd(C_BRKE);
		repeat (140) @(posedge clk_i);
		st;
		`CHK("brk min", 1'b1, brk_o)
		repeat (200) @(posedge clk_i);
		st;
		`CHK("brk off", 2'b01, {brk_o, txd_o})
		cmd(C_BRKE);
		st;
		`CHK("stray end", 1'b0, brk_o)
	endtask : t_brk

	task t_addr;
		wb(1'b1, OFF_CFG, 32'(PAR_MULTIDROP) << CFG_PAR_LSB);
		cmd(C_ADDR);
		wb(1'b1, OFF_TXC, 32'h0000_0041);
		st;
		`CHK("addr bit", 1'b1, addr_bit_o)
		wb(1'b1, OFF_TXC, 32'h0000_0042);
		st;
		`CHK("data bit", 1'b0, addr_bit_o)
		wb(1'b1, OFF_CFG, 32'h0000_0000);
		cmd(C_ADDR);
		wb(1'b1, OFF_TXC, 32'h0000_0043);
		st;
		`CHK("addr ignored", 1'b0, addr_bit_o)
	endtask : t_addr

	task end_sim;
		$display("Mismatches %0d, comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim

	initial begin
		#2000000;
		err_total++;
		end_sim;
	end

	initial begin
		{rst_i, cyc_i, stb_i, we_i, drv, lvl} = 6'b100_000;
		{tx_core_i, tx_idle_i} = 2'b11;
		adr_i = 8'h00;
		dat_i = 32'h0000_0000;
		ev = 9'h000;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_route;
		t_cmd;
		t_mode;
		t_flags;
		t_lock;
		t_brk;
		t_addr;
		end_sim;
	end
endmodule : tb_usart_control_test_modes_wprot
